// ---- design/ctp_prescale.sv ----
// module: count-pulse prescaler for the lower and upper timers
`timescale 1ns/1ns
module ctp_prescale
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] sel,
  input  wire logic       ext_rise,
  output logic            tick
);
  typedef struct packed
  {
    logic [1:0] fx_div;
    logic [2:0] ext_div;
    logic       tick;
  } ctp_pre_s;
  ctp_pre_s s_q;
  ctp_pre_s s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.fx_div = s_q.fx_div + 2'h1;
    if (ext_rise)
    begin
      s_d.ext_div = s_q.ext_div + 3'h1;
    end
    case (sel)
      ctp_pkg::CLK_FX:   s_d.tick = 1'b1;
      ctp_pkg::CLK_FX4:  s_d.tick = (s_q.fx_div == 2'h3);
      ctp_pkg::CLK_EXT:  s_d.tick = ext_rise;
      ctp_pkg::CLK_EXT2: s_d.tick = ext_rise && s_q.ext_div[0];
      ctp_pkg::CLK_EXT4: s_d.tick = ext_rise && (s_q.ext_div[1:0] == 2'h3);
      ctp_pkg::CLK_EXT8: s_d.tick = ext_rise && (s_q.ext_div == 3'h7);
      default:           s_d.tick = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// ---- design/ctp_top.sv ----
// module: cascaded timer pair with square wave, carrier and pwm modes
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module ctp_top
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        external_count_input,
  output logic             upper_timer_out,
  output logic             lower_timer_out,
  output logic             alt_timer_out,
  output logic             upper_match_irq,
  output logic             lower_match_irq
);
  typedef struct packed
  {
    logic        awready;
    logic        wready;
    logic        aw_hold;
    logic        w_hold;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        upper_run_enable;
    logic        lower_run_enable;
    logic        upper_output_enable;
    logic        lower_output_enable;
    logic        alt_output_enable;
    logic [1:0]  mode;
    logic [2:0]  lower_clk_sel;
    logic [2:0]  upper_clk_sel;
    logic [7:0]  upper_compare;
    logic [7:0]  lower_low_width_compare;
    logic [7:0]  lower_high_width_compare;
    logic        remote_output_select;
    logic        nrz_buffer_bit;
    logic        nrz_active_bit;
    logic [7:0]  upper_counter;
    logic [7:0]  lower_counter;
    logic        use_high;
    logic        wave;
    logic        upwm;
    logic        uirq;
    logic        lirq;
    logic        uo;
    logic        lo;
    logic        ao;
    logic [2:0]  ext_sync;
  } ctp_s;
  ctp_s s_q;
  ctp_s s_d;

  logic ltick;
  logic utick;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] ctrl_word(input ctp_s s);
    logic [31:0] r;
    r = ctp_pkg::RESET_WORD;
    r[ctp_pkg::CTRL_LRUN] = s.lower_run_enable;
    r[ctp_pkg::CTRL_URUN] = s.upper_run_enable;
    r[ctp_pkg::CTRL_LOE] = s.lower_output_enable;
    r[ctp_pkg::CTRL_AOE] = s.alt_output_enable;
    r[ctp_pkg::CTRL_UOE] = s.upper_output_enable;
    r[ctp_pkg::CTRL_MODE +: 2] = s.mode;
    r[ctp_pkg::CTRL_CLK +: 3] = s.lower_clk_sel;
    r[ctp_pkg::CTRL_UCLK +: 3] = s.upper_clk_sel;
    return r;
  endfunction

  // ************************************************************
  // count pulse prescalers
  // ************************************************************
  ctp_prescale u_lpre
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .sel      (s_q.lower_clk_sel),
    .ext_rise (s_q.ext_sync[1] && !s_q.ext_sync[2]),
    .tick     (ltick)
  );

  ctp_prescale u_upre
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .sel      (s_q.upper_clk_sel),
    .ext_rise (s_q.ext_sync[1] && !s_q.ext_sync[2]),
    .tick     (utick)
  );

  always_comb
  begin
    logic        wr;
    logic [31:0] w;
    logic        lmatch;
    logic        umatch;
    logic        cas;
    logic        car;
    logic        nrz_wr;
    logic        nrz_val;
    wr = 1'b0;
    w = ctp_pkg::RESET_WORD;
    lmatch = 1'b0;
    umatch = 1'b0;
    cas = (s_q.mode == ctp_pkg::MODE_CASCADE);
    car = (s_q.mode == ctp_pkg::MODE_CARRIER);
    nrz_wr = 1'b0;
    nrz_val = 1'b0;
    s_d = s_q;
    s_d.ext_sync = {s_q.ext_sync[1:0], external_count_input};
    s_d.uirq = 1'b0;
    s_d.lirq = 1'b0;

    // ************************************************************
    // axi4-lite slave
    // ************************************************************
    if (s_q.awready && s_axi_awvalid)
    begin
      s_d.awready = 1'b0;
      s_d.aw_hold = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid)
    begin
      s_d.wready = 1'b0;
      s_d.w_hold = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.aw_hold && s_q.w_hold && !s_q.bvalid)
    begin
      wr = 1'b1;
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = ctp_pkg::RESP_OKAY;
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end
    if (wr)
    begin
      case (s_q.awaddr)
        ctp_pkg::ADDR_CTRL:
        begin
          w = merge(ctrl_word(s_q), s_q.wdata, s_q.wstrb);
          s_d.lower_run_enable = w[ctp_pkg::CTRL_LRUN];
          s_d.upper_run_enable = w[ctp_pkg::CTRL_URUN];
          s_d.lower_output_enable = w[ctp_pkg::CTRL_LOE];
          s_d.alt_output_enable = w[ctp_pkg::CTRL_AOE];
          s_d.upper_output_enable = w[ctp_pkg::CTRL_UOE];
          s_d.mode = w[ctp_pkg::CTRL_MODE +: 2];
          s_d.lower_clk_sel = w[ctp_pkg::CTRL_CLK +: 3];
          s_d.upper_clk_sel = w[ctp_pkg::CTRL_UCLK +: 3];
          if (car && w[ctp_pkg::CTRL_LRUN] && !s_q.lower_run_enable)
          begin
            s_d.nrz_buffer_bit = 1'b0;
          end
        end
        ctp_pkg::ADDR_UCMP:
          if (s_q.wstrb[0]) s_d.upper_compare = s_q.wdata[7:0];
        ctp_pkg::ADDR_LCMP:
          if (s_q.wstrb[0]) s_d.lower_low_width_compare = s_q.wdata[7:0];
        ctp_pkg::ADDR_HCMP:
          if (s_q.wstrb[0]) s_d.lower_high_width_compare = s_q.wdata[7:0];
        ctp_pkg::ADDR_CARRIER:
          if (s_q.wstrb[0])
          begin
            s_d.remote_output_select = s_q.wdata[ctp_pkg::CAR_RMC];
            s_d.nrz_buffer_bit = s_q.wdata[ctp_pkg::CAR_NRZB];
            nrz_wr = !s_q.lower_output_enable;
            nrz_val = s_q.wdata[ctp_pkg::CAR_NRZ];
          end
        default:
          s_d.bresp = ctp_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.arready && s_axi_arvalid)
    begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = ctp_pkg::RESP_OKAY;
      s_d.rdata = ctp_pkg::RESET_WORD;
      case (s_axi_araddr)
        ctp_pkg::ADDR_CTRL:    s_d.rdata = ctrl_word(s_q);
        ctp_pkg::ADDR_UCMP:    s_d.rdata[7:0] = s_q.upper_compare;
        ctp_pkg::ADDR_LCMP:    s_d.rdata[7:0] = s_q.lower_low_width_compare;
        ctp_pkg::ADDR_HCMP:    s_d.rdata[7:0] = s_q.lower_high_width_compare;
        ctp_pkg::ADDR_CARRIER:
          s_d.rdata[2:0] = {s_q.remote_output_select, s_q.nrz_buffer_bit,
                            s_q.nrz_active_bit};
        ctp_pkg::ADDR_STATUS:
          s_d.rdata[2:0] = {s_q.use_high, s_q.upwm, s_q.wave};
        ctp_pkg::ADDR_COUNT:
          s_d.rdata[15:0] = {s_q.upper_counter, s_q.lower_counter};
        default:               s_d.rresp = ctp_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // ************************************************************
    // counters and modes
    // ************************************************************
    case (s_q.mode)
      ctp_pkg::MODE_CASCADE:
      begin
        if (!s_q.lower_run_enable)
        begin
          s_d.upper_counter = 8'h00;
          s_d.lower_counter = 8'h00;
          s_d.wave = 1'b0;
        end
        else if (ltick)
        begin
          lmatch = (s_q.lower_counter == s_q.lower_low_width_compare);
          umatch = (s_q.upper_counter == s_q.upper_compare);
          if (lmatch && umatch)
          begin
            s_d.upper_counter = 8'h00;
            s_d.lower_counter = 8'h00;
            s_d.wave = !s_q.wave;
            s_d.lirq = 1'b1;
          end
          else
          begin
            s_d.lower_counter = s_q.lower_counter + 8'h01;
            if (s_q.lower_counter == 8'hff)
            begin
              s_d.upper_counter = s_q.upper_counter + 8'h01;
            end
          end
        end
      end
      ctp_pkg::MODE_CARRIER:
      begin
        if (!s_q.lower_run_enable)
        begin
          s_d.lower_counter = 8'h00;
          s_d.use_high = 1'b0;
          s_d.wave = 1'b0;
        end
        else if (ltick)
        begin
          lmatch = s_q.use_high ?
                   (s_q.lower_counter == s_q.lower_high_width_compare) :
                   (s_q.lower_counter == s_q.lower_low_width_compare);
          if (lmatch)
          begin
            s_d.lower_counter = 8'h00;
            s_d.lirq = 1'b1;
            s_d.wave = !s_q.wave;
            s_d.use_high = !s_q.use_high;
          end
          else
          begin
            s_d.lower_counter = s_q.lower_counter + 8'h01;
          end
        end
        if (!s_q.upper_run_enable)
        begin
          s_d.upper_counter = 8'h00;
        end
        else if (utick)
        begin
          if (s_q.upper_counter == s_q.upper_compare)
          begin
            s_d.upper_counter = 8'h00;
            s_d.uirq = 1'b1;
            nrz_wr = 1'b1;
            nrz_val = s_q.nrz_buffer_bit;
          end
          else
          begin
            s_d.upper_counter = s_q.upper_counter + 8'h01;
          end
        end
      end
      ctp_pkg::MODE_PWM:
      begin
        if (!s_q.upper_run_enable)
        begin
          s_d.upper_counter = 8'h00;
          s_d.upwm = 1'b0;
        end
        else if (utick)
        begin
          s_d.upper_counter = s_q.upper_counter + 8'h01;
          if (s_q.upper_counter == s_q.upper_compare)
          begin
            s_d.uirq = 1'b1;
            s_d.upwm = 1'b0;
          end
          else if (s_q.upper_counter == 8'hff)
          begin
            s_d.upwm = 1'b1;
          end
        end
      end
      default:
      begin
        s_d.upper_counter = 8'h00;
        s_d.lower_counter = 8'h00;
        s_d.wave = 1'b0;
        s_d.upwm = 1'b0;
      end
    endcase
    if (nrz_wr)
    begin
      s_d.nrz_active_bit = nrz_val;
    end

    // ************************************************************
    // output pins
    // ************************************************************
    if (car)
    begin
      s_d.lo = s_q.lower_output_enable && s_q.nrz_active_bit &&
               s_q.wave;
    end
    else
    begin
      s_d.lo = s_q.lower_output_enable && s_q.wave;
    end
    s_d.ao = s_q.alt_output_enable && (car ? (s_q.nrz_active_bit &&
             s_q.wave) : s_q.wave);
    s_d.uo = s_q.upper_output_enable && !cas && s_q.upwm;
    if (!s_q.lower_output_enable && s_d.lower_output_enable &&
        !s_d.alt_output_enable)
    begin
      s_d.wave = 1'b0;
    end
    if (!s_q.alt_output_enable && s_d.alt_output_enable &&
        !s_d.lower_output_enable)
    begin
      s_d.wave = 1'b0;
    end
    if (!s_q.upper_output_enable && s_d.upper_output_enable)
    begin
      s_d.upwm = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign upper_timer_out = s_q.uo;
  assign lower_timer_out = s_q.lo;
  assign alt_timer_out = s_q.ao;
  assign upper_match_irq = s_q.uirq;
  assign lower_match_irq = s_q.lirq;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking ctp_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_cas_no_uirq: assert property (
    s_q.mode == ctp_pkg::MODE_CASCADE &&
    $past(s_q.mode) == ctp_pkg::MODE_CASCADE |-> !upper_match_irq)
    else $error("upper irq in cascade mode");
  a_cas_clear: assert property (
    s_q.lirq && s_q.mode == ctp_pkg::MODE_CASCADE && $stable(s_q.mode) |->
    s_q.upper_counter == 8'h00 && s_q.lower_counter == 8'h00)
    else $error("cascade match did not clear counters");
  a_cas_toggle: assert property (
    s_q.lirq && s_q.mode == ctp_pkg::MODE_CASCADE && $stable(s_q.mode)
    |-> s_q.wave != $past(s_q.wave))
    else $error("square wave did not toggle");
  a_run_off_low: assert property (
    s_q.mode == ctp_pkg::MODE_CASCADE && !s_q.lower_run_enable |=> !s_q.wave)
    else $error("square wave not forced low");
  a_nrz_hold: assert property (
    s_q.lower_output_enable && !s_q.uirq |=>
    $stable(s_q.nrz_active_bit) || s_q.uirq)
    else $error("active nrz changed while output enabled");
  a_nrz_reload: assert property (
    s_q.uirq && s_q.mode == ctp_pkg::MODE_CARRIER |->
    s_q.nrz_active_bit == $past(s_q.nrz_buffer_bit))
    else $error("nrz not reloaded on upper match");
  a_car_gate: assert property (
    s_q.mode == ctp_pkg::MODE_CARRIER && !s_q.nrz_active_bit |=>
    !lower_timer_out)
    else $error("carrier passed with nrz low");
  a_pwm_low: assert property (
    s_q.mode == ctp_pkg::MODE_PWM && s_q.uirq && $stable(s_q.mode) |->
    !s_q.upwm && s_q.upper_counter == $past(s_q.upper_counter) + 8'h01)
    else $error("pwm match did not drive low");
  a_pwm_high: assert property (
    s_q.mode == ctp_pkg::MODE_PWM && s_q.upper_run_enable && utick &&
    s_q.upper_counter == 8'hff && s_q.upper_compare != 8'hff &&
    $stable(s_q.mode) |=> s_q.upwm)
    else $error("pwm overflow did not drive high");
  a_car_irq: assert property (
    s_q.lirq && s_q.mode == ctp_pkg::MODE_CARRIER && $stable(s_q.mode)
    |-> s_q.use_high != $past(s_q.use_high))
    else $error("carrier compare did not switch");
endmodule

// ---- inc/ctp_pkg.sv ----
// package: register map, field positions, modes and clock selects
package ctp_pkg;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_UCMP    = 8'h04;
  localparam logic [7:0] ADDR_LCMP    = 8'h08;
  localparam logic [7:0] ADDR_HCMP    = 8'h0c;
  localparam logic [7:0] ADDR_CARRIER = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;
  localparam logic [7:0] ADDR_COUNT   = 8'h18;
  // ctrl field positions
  localparam int CTRL_LRUN  = 0;
  localparam int CTRL_URUN  = 1;
  localparam int CTRL_LOE   = 2;
  localparam int CTRL_AOE   = 3;
  localparam int CTRL_UOE   = 4;
  localparam int CTRL_MODE  = 5;
  localparam int CTRL_CLK   = 8;
  localparam int CTRL_UCLK  = 12;
  // carrier ctrl field positions
  localparam int CAR_NRZ    = 0;
  localparam int CAR_NRZB   = 1;
  localparam int CAR_RMC    = 2;
  // modes
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_CASCADE = 2'h1;
  localparam logic [1:0] MODE_CARRIER = 2'h2;
  localparam logic [1:0] MODE_PWM     = 2'h3;
  // clock selects for the lower and upper timers
  localparam logic [2:0] CLK_FX      = 3'h0;
  localparam logic [2:0] CLK_FX4     = 3'h1;
  localparam logic [2:0] CLK_EXT     = 3'h2;
  localparam logic [2:0] CLK_EXT2    = 3'h3;
  localparam logic [2:0] CLK_EXT4    = 3'h4;
  localparam logic [2:0] CLK_EXT8    = 3'h5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// ---- verif/ctp_ext_model.sv ----
// far-side model: external count source wired to the timer pin input
`timescale 1ns/1ns
module ctp_ext_model
(
  output logic ext_in
);
  // ****
  // free-running source, phase unrelated to aclk, period 3 clocks
  // ****
  initial
  begin
    ext_in = 1'b0;
    #7;
    forever #60 ext_in = ~ext_in;
  end
endmodule

// ---- verif/testbench.sv ----
// testbench: register-bus scenarios for the cascaded timer pair
`timescale 1ns/1ns
module testbench;
  // ****
  // signals
  // ****
  localparam logic [7:0] CT = ctp_pkg::ADDR_CTRL;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rd;
  logic [1:0]  rr;
  logic        rvalid;
  logic        rready;
  logic        ext_in;
  logic        uo;
  logic        lo;
  logic        ao;
  logic        uirq;
  logic        lirq;
  int          n_fail;
  int          comparisons;
  int          cyc;
  ctp_ext_model ext (.ext_in(ext_in));
  ctp_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_count_input(ext_in), .upper_timer_out(uo),
    .lower_timer_out(lo), .alt_timer_out(ao), .upper_match_irq(uirq),
    .lower_match_irq(lirq));
  // ****
  // clock, timeout, tasks
  // ****
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      t++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 200);
    if (bvalid !== 1'b1)
      n_fail++;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      t++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 200);
    if (rvalid !== 1'b1)
      n_fail++;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = lirq;
      1: pick = uirq;
      2: pick = lo;
      default: pick = uo;
    endcase
  endfunction
  // cycles between two pulses of the chosen signal
  task automatic gap(input int w, output int g);
    int t;
    t = 0;
    while (pick(w) !== 1'b1 && t < 9000)
    begin
      @(posedge aclk);
      t++;
    end
    g = 0;
    do
    begin
      @(posedge aclk);
      g++;
    end while (pick(w) !== 1'b1 && g < 9000);
  endtask
  task automatic edges(input int w, input int n, output int c);
    logic p;
    c = 0;
    p = pick(w);
    repeat (n)
    begin
      @(posedge aclk);
      if (pick(w) === 1'b1 && p !== 1'b1)
        c++;
      p = pick(w);
    end
  endtask
  function automatic logic [31:0] cw(input logic [4:0] e,
      input logic [1:0] m, input logic [2:0] lc, input logic [2:0] uc);
    cw = 32'h0;
    cw[4:0] = e;
    cw[ctp_pkg::CTRL_MODE +: 2] = m;
    cw[ctp_pkg::CTRL_CLK +: 3] = lc;
    cw[ctp_pkg::CTRL_UCLK +: 3] = uc;
  endfunction
  task automatic casc(input logic [2:0] s, input logic [7:0] u,
                      input logic [7:0] l, input logic [4:0] oe);
    axw(CT, 32'h0);
    axw(CT, cw(oe, ctp_pkg::MODE_OFF, s, 3'h0));
    chk("pin at enable", 32'h0, {30'h0, lo, ao});
    axw(CT, cw(oe, ctp_pkg::MODE_CASCADE, s, 3'h0));
    axw(ctp_pkg::ADDR_UCMP, {24'h0, u});
    axw(ctp_pkg::ADDR_LCMP, {24'h0, l});
    axw(CT, cw(oe | 5'h01, ctp_pkg::MODE_CASCADE, s, 3'h0));
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs();
    axr(CT);
    chk("ctrl reset", ctp_pkg::RESET_WORD, rd);
    axr(8'h3c);
    chk("unmapped read", {30'h0, ctp_pkg::RESP_SLVERR}, {30'h0, rr});
    axw(8'h3c, 32'h1);
    chk("unmapped write", {30'h0, ctp_pkg::RESP_SLVERR}, {30'h0, bresp});
  endtask
  task automatic t_cascade();
    int g;
    int c;
    logic p0;
    casc(ctp_pkg::CLK_FX, 8'h01, 8'h02, 5'h04);
    axw(CT, cw(5'h07, ctp_pkg::MODE_CASCADE, ctp_pkg::CLK_FX, 3'h0));
    gap(0, g);
    gap(0, g);
    p0 = lo;
    chk("joint match period", 32'd259, g);
    repeat (4) @(posedge aclk);
    chk("square wave toggle", {31'h0, ~p0}, {31'h0, lo});
    edges(1, 600, c);
    chk("upper irq silent", 32'd0, c);
    while (lo !== 1'b1 && g < 9000)
    begin
      @(posedge aclk);
      g++;
    end
    if (lo !== 1'b1)
      n_fail++;
    axw(CT, cw(5'h06, ctp_pkg::MODE_CASCADE, ctp_pkg::CLK_FX, 3'h0));
    repeat (3) @(posedge aclk);
    chk("wave cleared on stop", 32'h0, {31'h0, lo});
  endtask
  task automatic t_clksel();
    int dv[6] = '{1, 4, 3, 6, 12, 24};
    int g;
    for (int s = 0; s < 6; s++)
    begin
      casc(3'(s), 8'h00, 8'h03, 5'h08);
      gap(0, g);
      gap(0, g);
      chk("clock select period", 32'(4 * dv[s]), g);
    end
  endtask
  task automatic t_carrier();
    int g1;
    int g2;
    int c;
    axw(CT, 32'h0);
    axw(ctp_pkg::ADDR_UCMP, 32'hff);
    axw(ctp_pkg::ADDR_LCMP, 32'h2);
    axw(ctp_pkg::ADDR_HCMP, 32'h4);
    axw(ctp_pkg::ADDR_CARRIER, 32'h0);
    axw(CT, cw(5'h07, ctp_pkg::MODE_CARRIER, 3'h0, ctp_pkg::CLK_FX4));
    repeat (20) @(posedge aclk);
    axw(ctp_pkg::ADDR_CARRIER, 32'h3);
    axr(ctp_pkg::ADDR_CARRIER);
    chk("nrz write locked", 32'h2, {29'h0, rd[2:0]});
    edges(2, 200, c);
    chk("pin held low", 32'h0, c);
    gap(0, g1);
    gap(0, g2);
    chk("carrier period", 32'd8, g1 + g2);
    gap(1, g1);
    edges(2, 60, c);
    chk("carrier after reload", 32'h1, {31'h0, c > 0});
  endtask
  task automatic t_pwm();
    int g;
    axw(CT, 32'h0);
    axw(ctp_pkg::ADDR_UCMP, 32'h40);
    axw(CT, cw(5'h10, ctp_pkg::MODE_PWM, 3'h0, ctp_pkg::CLK_FX));
    axw(CT, cw(5'h12, ctp_pkg::MODE_PWM, 3'h0, ctp_pkg::CLK_FX));
    gap(1, g);
    chk("pwm period", 32'd256, g);
    while (uo !== 1'b0 && g < 9000)
    begin
      @(posedge aclk);
      g++;
    end
    while (uo !== 1'b1 && g < 9000)
    begin
      @(posedge aclk);
      g++;
    end
    g = 0;
    while (uo === 1'b1 && g < 9000)
    begin
      @(posedge aclk);
      g++;
    end
    chk("pwm high time", 32'd65, g);
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    aresetn = 1'b0;
    awaddr = 8'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_cascade();
    t_clksel();
    t_carrier();
    t_pwm();
    stop_test();
  end
endmodule
